/* rtl/cml_logic_block.sv */
`timescale 1ns/10ps
`include "cml_map.svh"
module cml_logic_block #(
	parameter int CLK_N = `CML_CLK_TWO,
	parameter int IO_N = `CML_IO_FULL
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire cml_pkg::cml_blk_cfg_t blkCfg,
	input wire cml_pkg::cml_mc_cfg_t mcCfg [`CML_NUM_MC],
	input wire cml_pkg::cml_in_cfg_t inCfg [`CML_NUM_INS],
	input wire logic [`CML_PT_TOTAL-1:0] ptTerms,
	input wire logic [`CML_OE_TERMS-1:0] oeTerms,
	input wire logic setTerm,
	input wire logic rstTerm,
	input wire logic [IO_N-1:0] ioPinIn,
	input wire logic [`CML_NUM_INS-1:0] insPinIn,
	output logic [IO_N-1:0] ioPinOut,
	output logic [IO_N-1:0] ioPinOe_n,
	output logic [`CML_NUM_MC-1:0] mcFeedback,
	output logic [`CML_NUM_INS-1:0] inFeedback
);
	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	localparam bit REG_INT = (IO_N == `CML_IO_REG);

	initial begin
		if (CLK_N != `CML_CLK_TWO && CLK_N != `CML_CLK_FOUR) begin
			$error("CLK_N must be two or four");
		end
		if (IO_N != `CML_IO_REG && IO_N != `CML_IO_FULL) begin
			$error("IO_N must be eight or sixteen");
		end
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [IO_N-1:0] ioS1_q;
	logic [IO_N-1:0] ioS2_q;
	logic [`CML_NUM_INS-1:0] insS1_q;
	logic [`CML_NUM_INS-1:0] insS2_q;
	logic [`CML_NUM_INS-1:0] insPrev_q;

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ioS1_q <= '0;
			ioS2_q <= '0;
			insS1_q <= '0;
			insS2_q <= '0;
			insPrev_q <= '0;
		end else begin
			ioS1_q <= ioPinIn;
			ioS2_q <= ioS1_q;
			insS1_q <= insPinIn;
			insS2_q <= insS1_q;
			insPrev_q <= insS2_q;
		end
	end

	// ------------------------------------------------------------
	// clock network
	// ------------------------------------------------------------
	// low CLK_N inputs are input/clock pins, the rest are plain inputs
	logic [`CML_CLK_FOUR-1:0] outEvt;
	logic [`CML_CLK_FOUR-1:0] outLvl;
	logic [`CML_CLK_FOUR-1:0] inEvt;
	logic [`CML_CLK_FOUR-1:0] inLvl;

	for (genvar c = 0; c < `CML_CLK_FOUR; c++) begin : g_clk
		if (c < CLK_N) begin : g_used
			logic rise;
			logic fall;
			assign rise = insS2_q[c] && !insPrev_q[c];
			assign fall = !insS2_q[c] && insPrev_q[c];
			assign outEvt[c] = blkCfg.outClkInv ? fall : rise;
			assign outLvl[c] = insS2_q[c] ^ blkCfg.outClkInv;
			assign inEvt[c] = blkCfg.inClkInv ? fall : rise;
			assign inLvl[c] = insS2_q[c] ^ blkCfg.inClkInv;
		end else begin : g_unused
			assign outEvt[c] = 1'b0;
			assign outLvl[c] = 1'b0;
			assign inEvt[c] = 1'b0;
			assign inLvl[c] = 1'b0;
		end
	end

	function automatic logic [1:0] clkIdx(input logic [1:0] sel);
		clkIdx = (CLK_N == `CML_CLK_TWO) ? {1'b0, sel[0]} : sel;
	endfunction : clkIdx

	// ------------------------------------------------------------
	// macrocells
	// ------------------------------------------------------------
	logic setA;
	logic rstA;
	logic [`CML_NUM_MC-1:0] mcState;
	logic [`CML_NUM_MC-1:0] mcResult;

	assign setA = setTerm ^ blkCfg.setInv;
	assign rstA = rstTerm ^ blkCfg.rstInv;

	for (genvar m = 0; m < `CML_NUM_MC; m++) begin : g_mc
		localparam int GRP = m / `CML_GROUP;
		localparam int LANE = m % `CML_GROUP;
		localparam bit BURIED = REG_INT && (m % 2 == 1);
		logic [`CML_PT_POOL-1:0] pool;
		logic [`CML_MC_PT-1:0] window;
		logic sum;
		logic dIn;
		logic [1:0] ck;
		cml_pkg::cml_mc_mode_t mode;

		// overlapping windows let adjacent macrocells of a group share terms
		assign pool = ptTerms[GRP*`CML_PT_POOL +: `CML_PT_POOL];
		assign window = pool[LANE +: `CML_MC_PT];
		assign sum = |(window & mcCfg[m].ptMask);
		assign ck = clkIdx(mcCfg[m].clkSel);

		if (BURIED) begin : g_buried
			// input register mode captures the neighbouring I/O pin
			assign dIn = mcCfg[m].inRegEn ? ioS2_q[m/2] : sum;
			assign mode = !mcCfg[m].inRegEn ? mcCfg[m].mode
				: (mcCfg[m].mode == cml_pkg::CML_MC_LATCH) ? cml_pkg::CML_MC_LATCH
				: cml_pkg::CML_MC_DFF;
		end else begin : g_io
			assign dIn = sum;
			assign mode = mcCfg[m].mode;
		end

		cml_mc_store u_store (
			.mclk(mclk),
			.rst_n(rst_n),
			.mode(mode),
			.dIn(dIn),
			.clkEvt(outEvt[ck]),
			.clkLvl(outLvl[ck]),
			.setA(setA),
			.rstA(rstA),
			.stateQ(mcState[m])
		);

		assign mcResult[m] = mcState[m] ^ mcCfg[m].outInv;
	end

	// ------------------------------------------------------------
	// feedback and I/O cells
	// ------------------------------------------------------------
	logic [`CML_NUM_MC-1:0] fb_d;
	logic [`CML_NUM_MC-1:0] fb_q;
	logic [IO_N-1:0] pinOut_d;
	logic [IO_N-1:0] pinOut_q;
	logic [IO_N-1:0] pinOe_n_d;
	logic [IO_N-1:0] pinOe_n_q;

	always_comb begin
		fb_d = mcResult;
		pinOut_d = '0;
		pinOe_n_d = '1;
		for (int p = 0; p < IO_N; p++) begin
			int m;
			int half;
			m = REG_INT ? 2 * p : p;
			half = (m < `CML_NUM_MC / 2) ? 0 : 1;
			pinOut_d[p] = mcResult[m];
			case (mcCfg[m].oeMode)
				cml_pkg::CML_OE_ON: pinOe_n_d[p] = 1'b0;
				cml_pkg::CML_OE_OFF: pinOe_n_d[p] = 1'b1;
				cml_pkg::CML_OE_PT0: pinOe_n_d[p] = !oeTerms[half*`CML_OE_PER_HALF];
				cml_pkg::CML_OE_PT1: pinOe_n_d[p] = !oeTerms[half*`CML_OE_PER_HALF+1];
				default: pinOe_n_d[p] = 1'b1;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			fb_q <= '0;
			pinOut_q <= '0;
			pinOe_n_q <= '1;
		end else begin
			fb_q <= fb_d;
			pinOut_q <= pinOut_d;
			pinOe_n_q <= pinOe_n_d;
		end
	end

	assign mcFeedback = fb_q;
	assign ioPinOut = pinOut_q;
	assign ioPinOe_n = pinOe_n_q;

	// ------------------------------------------------------------
	// dedicated and input/clock pin capture
	// ------------------------------------------------------------
	logic [`CML_NUM_INS-1:0] st1_d;
	logic [`CML_NUM_INS-1:0] st1_q;
	logic [`CML_NUM_INS-1:0] st2_d;
	logic [`CML_NUM_INS-1:0] st2_q;
	logic [`CML_NUM_INS-1:0] inFb_d;
	logic [`CML_NUM_INS-1:0] inFb_q;

	always_comb begin
		st1_d = st1_q;
		st2_d = st2_q;
		inFb_d = '0;
		for (int i = 0; i < `CML_NUM_INS; i++) begin
			logic [1:0] ck;
			ck = clkIdx(inCfg[i].clkSel);
			if (CLK_N == `CML_CLK_TWO && i < CLK_N) begin
				ck = 2'(i ^ 1);
			end
			case (inCfg[i].mode)
				cml_pkg::CML_IN_COMB: begin
					inFb_d[i] = insS2_q[i];
				end
				cml_pkg::CML_IN_REG: begin
					if (inEvt[ck]) st1_d[i] = insS2_q[i];
					inFb_d[i] = st1_q[i];
				end
				cml_pkg::CML_IN_DREG: begin
					if (inEvt[ck]) begin
						st1_d[i] = insS2_q[i];
						st2_d[i] = st1_q[i];
					end
					inFb_d[i] = st2_q[i];
				end
				cml_pkg::CML_IN_LATCH: begin
					if (inLvl[ck]) st1_d[i] = insS2_q[i];
					inFb_d[i] = st1_q[i];
				end
				default: inFb_d[i] = 1'b0;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			st1_q <= '0;
			st2_q <= '0;
			inFb_q <= '0;
		end else begin
			st1_q <= st1_d;
			st2_q <= st2_d;
			inFb_q <= inFb_d;
		end
	end

	assign inFeedback = inFb_q;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_oe_forced_off: assert property (mcCfg[0].oeMode == cml_pkg::CML_OE_OFF |=> ioPinOe_n[0])
		else $error("pin driven while enable off");
	a_oe_forced_on: assert property (mcCfg[0].oeMode == cml_pkg::CML_OE_ON |=> !ioPinOe_n[0])
		else $error("pin not driven while enable on");
	a_oe_term_drive: assert property (mcCfg[0].oeMode == cml_pkg::CML_OE_PT1
		|=> ioPinOe_n[0] == !$past(oeTerms[1])) else $error("enable term not followed");
	a_oe_first_term: assert property (mcCfg[0].oeMode == cml_pkg::CML_OE_PT0
		|=> ioPinOe_n[0] == !$past(oeTerms[0])) else $error("first enable term not followed");
	a_fb_polarity: assert property (1'b1
		|=> mcFeedback[0] == ($past(mcState[0]) ^ $past(mcCfg[0].outInv)))
		else $error("feedback polarity wrong");
	a_rst_to_fb: assert property (rstA && !mcCfg[1].outInv ##1 !mcCfg[1].outInv |=> !mcFeedback[1])
		else $error("reset term did not reach feedback");
	a_in_comb: assert property (inCfg[5].mode == cml_pkg::CML_IN_COMB
		|=> inFeedback[5] == $past(insS2_q[5])) else $error("combinatorial input wrong");
	a_dreg_chain: assert property (inCfg[5].mode == cml_pkg::CML_IN_DREG && inEvt[clkIdx(inCfg[5].clkSel)]
		|=> st2_q[5] == $past(st1_q[5])) else $error("second stage did not follow first");
	a_pin_follows: assert property (mcCfg[0].oeMode == cml_pkg::CML_OE_ON
		|=> ioPinOut[0] == $past(mcResult[0])) else $error("pin output wrong");
	a_in_reg_hold: assert property (inCfg[3].mode == cml_pkg::CML_IN_REG && !inEvt[clkIdx(inCfg[3].clkSel)]
		|=> $stable(st1_q[3])) else $error("input register moved without clock");
	a_in_latch_hold: assert property (inCfg[5].mode == cml_pkg::CML_IN_LATCH
		&& !inLvl[clkIdx(inCfg[5].clkSel)] |=> $stable(st1_q[5])) else $error("closed input latch moved");
	a_out_fall_evt: assert property (blkCfg.outClkInv && insPrev_q[0] && !insS2_q[0] |-> outEvt[0])
		else $error("falling clock edge missed");
	a_out_rise_ign: assert property (blkCfg.outClkInv && !insPrev_q[0] && insS2_q[0] |-> !outEvt[0])
		else $error("rising edge used while inverted");
	a_clk_pol_sep: assert property (blkCfg.inClkInv && !blkCfg.outClkInv && !insPrev_q[0] && insS2_q[0]
		|-> outEvt[0] && !inEvt[0]) else $error("clock polarities not separate");

	// ------------------------------------------------------------
	// variant checks
	// ------------------------------------------------------------
	if (CLK_N == `CML_CLK_TWO) begin : g_chk_swap
		a_swap_clock: assert property (@(posedge mclk) disable iff (!rst_n)
			inCfg[0].mode == cml_pkg::CML_IN_REG && inEvt[1] |=> st1_q[0] == $past(insS2_q[0]))
			else $error("input clock pin not clocked by the other");
	end
	if (REG_INT) begin : g_chk_buried
		a_buried_input: assert property (@(posedge mclk) disable iff (!rst_n)
			mcCfg[1].inRegEn && mcCfg[1].mode == cml_pkg::CML_MC_DFF && !setA && !rstA
			&& outEvt[clkIdx(mcCfg[1].clkSel)] |=> mcState[1] == $past(ioS2_q[0]))
			else $error("buried input register missed its pin");
	end

	c_toggle_mode: cover property (mcCfg[0].mode == cml_pkg::CML_MC_TFF && outEvt[0] ##1 mcState[0]);
	c_dreg_input: cover property (inCfg[4].mode == cml_pkg::CML_IN_DREG && inEvt[0] ##2 inFeedback[4]);
	c_oe_dynamic: cover property (mcCfg[2].oeMode == cml_pkg::CML_OE_PT0 ##1 !ioPinOe_n[2] ##1 ioPinOe_n[2]);
	c_fall_clock: cover property (blkCfg.outClkInv && outEvt[0]);
	c_buried_input: cover property (mcCfg[1].inRegEn && outEvt[3] ##2 mcFeedback[1]);
endmodule : cml_logic_block

/* rtl/cml_map.svh */
`ifndef CML_MAP_SVH
`define CML_MAP_SVH
`define CML_NUM_MC 16
`define CML_MC_PT 16
`define CML_GROUP 4
`define CML_PT_POOL 20
`define CML_PT_TOTAL 80
`define CML_NUM_INS 6
`define CML_CLK_TWO 2
`define CML_CLK_FOUR 4
`define CML_OE_TERMS 4
`define CML_OE_PER_HALF 2
`define CML_IO_REG 8
`define CML_IO_FULL 16
`endif

/* rtl/cml_mc_store.sv */
`timescale 1ns/10ps
module cml_mc_store (
	input wire logic mclk,
	input wire logic rst_n,
	input wire cml_pkg::cml_mc_mode_t mode,
	input wire logic dIn,
	input wire logic clkEvt,
	input wire logic clkLvl,
	input wire logic setA,
	input wire logic rstA,
	output logic stateQ
);
	logic state_d;
	logic state_q;

	always_comb begin
		state_d = state_q;
		if (rstA) begin
			state_d = 1'b0;
		end else if (setA) begin
			state_d = 1'b1;
		end else begin
			case (mode)
				cml_pkg::CML_MC_COMB: state_d = dIn;
				cml_pkg::CML_MC_DFF: if (clkEvt) state_d = dIn;
				cml_pkg::CML_MC_TFF: if (clkEvt && dIn) state_d = ~state_q;
				cml_pkg::CML_MC_LATCH: if (clkLvl) state_d = dIn;
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			state_q <= 1'b0;
		end else begin
			state_q <= state_d;
		end
	end

	assign stateQ = state_q;

	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	a_reset_wins: assert property (rstA |=> !stateQ) else $error("reset term did not clear");
	a_set_forces: assert property (setA && !rstA |=> stateQ) else $error("set term did not set");
	a_toggle_edge: assert property (mode == cml_pkg::CML_MC_TFF && clkEvt && dIn && !setA && !rstA
		|=> stateQ != $past(stateQ)) else $error("t mode did not toggle");
	a_dff_holds: assert property (mode == cml_pkg::CML_MC_DFF && !clkEvt && !setA && !rstA
		|=> $stable(stateQ)) else $error("d mode changed without edge");
	a_latch_pass: assert property (mode == cml_pkg::CML_MC_LATCH && clkLvl && !setA && !rstA
		|=> stateQ == $past(dIn)) else $error("open latch not transparent");
endmodule : cml_mc_store

/* rtl/cml_pkg.sv */
`include "cml_map.svh"
package cml_pkg;
	typedef enum logic [1:0] {CML_MC_COMB, CML_MC_DFF, CML_MC_TFF, CML_MC_LATCH} cml_mc_mode_t;
	typedef enum logic [1:0] {CML_IN_COMB, CML_IN_REG, CML_IN_DREG, CML_IN_LATCH} cml_in_mode_t;
	typedef enum logic [1:0] {CML_OE_ON, CML_OE_OFF, CML_OE_PT0, CML_OE_PT1} cml_oe_mode_t;
	typedef struct packed {
		cml_mc_mode_t mode;
		logic [1:0] clkSel;
		logic outInv;
		logic inRegEn;
		logic [`CML_MC_PT-1:0] ptMask;
		cml_oe_mode_t oeMode;
	} cml_mc_cfg_t;
	typedef struct packed {
		cml_in_mode_t mode;
		logic [1:0] clkSel;
	} cml_in_cfg_t;
	typedef struct packed {
		logic outClkInv;
		logic inClkInv;
		logic setInv;
		logic rstInv;
	} cml_blk_cfg_t;
endpackage : cml_pkg

/* verif/cml_pin_model.sv */
`timescale 1ns/10ps
module cml_pin_model (
	input wire logic [15:0] ioPinOut,
	input wire logic [15:0] ioPinOe_n,
	input wire logic [15:0] extPin,
	output logic [15:0] ioPinIn
);
	// --------------------------------
	// pin wire: block drives while its enable is low, else the outside source
	// --------------------------------
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			ioPinIn[k] = ioPinOe_n[k] ? extPin[k] : ioPinOut[k];
		end
	end
endmodule : cml_pin_model

/* verif/tb_cml_logic_block.sv */
`timescale 1ns/10ps
`include "cml_map.svh"
module tb_cml_logic_block;
	// --------------------------------
	// signals
	// --------------------------------
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	cml_pkg::cml_blk_cfg_t blkCfg = '0;
	cml_pkg::cml_mc_cfg_t mcCfg [`CML_NUM_MC];
	cml_pkg::cml_in_cfg_t inCfg [`CML_NUM_INS];
	logic [79:0] ptTerms = '0;
	logic [3:0] oeTerms = '0;
	logic setTerm = 1'b0;
	logic rstTerm = 1'b0;
	logic [15:0] extPin = '0;
	logic [15:0] ioPinIn, ioPinOut, ioPinOe_n, mcFeedback;
	logic [5:0] insPinIn = '0;
	logic [5:0] inFeedback;
	logic [7:0] regPinOut, regPinOe_n;
	logic [15:0] regFeedback;
	int errorCnt = 0;
	int totalChecks = 0;
	always #5 mclk = ~mclk;
	cml_logic_block cml_logic_block_i (.mclk(mclk), .rst_n(rst_n), .blkCfg(blkCfg), .mcCfg(mcCfg),
		.inCfg(inCfg), .ptTerms(ptTerms), .oeTerms(oeTerms), .setTerm(setTerm), .rstTerm(rstTerm),
		.ioPinIn(ioPinIn), .insPinIn(insPinIn), .ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n),
		.mcFeedback(mcFeedback), .inFeedback(inFeedback));
	cml_pin_model cml_pin_model_i (.ioPinOut(ioPinOut), .ioPinOe_n(ioPinOe_n), .extPin(extPin),
		.ioPinIn(ioPinIn));
	// register-intensive, four-clock variant: odd macrocells are buried
	cml_logic_block #(.CLK_N(`CML_CLK_FOUR), .IO_N(`CML_IO_REG)) cml_logic_block_ri (.mclk(mclk),
		.rst_n(rst_n), .blkCfg(blkCfg), .mcCfg(mcCfg), .inCfg(inCfg), .ptTerms(ptTerms), .oeTerms(oeTerms),
		.setTerm(setTerm), .rstTerm(rstTerm), .ioPinIn(extPin[7:0]), .insPinIn(insPinIn),
		.ioPinOut(regPinOut), .ioPinOe_n(regPinOe_n), .mcFeedback(regFeedback), .inFeedback());
	// --------------------------------
	// tasks
	// --------------------------------
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk);
	endtask : cyc
	task automatic chk(input string n, input logic s, input logic e);
		totalChecks++;
		if (s !== e) begin
			errorCnt++;
			$display("[ERR] %s exp %b got %b", n, e, s);
		end
	endtask : chk
	task automatic stop_test;
		$display("checks %0d errors %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test
	// one clock-pin pulse; each half leaves room for sync, edge detect and output
	task automatic pulse(input int i);
		insPinIn[i] = 1'b1;
		cyc(4);
		insPinIn[i] = 1'b0;
		cyc(4);
	endtask : pulse
	task automatic setMc(input int m, input cml_pkg::cml_mc_mode_t md, input logic [1:0] cs, input logic [15:0] mk);
		mcCfg[m].mode = md;
		mcCfg[m].clkSel = cs;
		mcCfg[m].ptMask = mk;
	endtask : setMc
	task automatic t_comb;
		setMc(0, cml_pkg::CML_MC_COMB, 2'h0, 16'h0002);
		setMc(1, cml_pkg::CML_MC_COMB, 2'h0, 16'h0001);
		ptTerms[1] = 1'b1;
		cyc(3);
		chk("shareA", mcFeedback[0], 1'b1);
		chk("shareB", mcFeedback[1], 1'b1);
		chk("pin0", ioPinOut[0], 1'b1);
		mcCfg[1].outInv = 1'b1;
		cyc(3);
		chk("inv", mcFeedback[1], 1'b0);
		chk("invPin", ioPinOut[1], 1'b0);
		mcCfg[0].ptMask = 16'h0000;
		mcCfg[1].outInv = 1'b0;
		cyc(3);
		chk("noTerm", mcFeedback[0], 1'b0);
		ptTerms = '0;
		$display("comb done");
	endtask : t_comb
	task automatic t_oe;
		for (int k = 0; k < 4; k++) begin
			for (int p = 0; p < 2; p++) begin
				oeTerms = p ? 4'ha : 4'h5;
				mcCfg[0].oeMode = cml_pkg::cml_oe_mode_t'(k);
				mcCfg[8].oeMode = cml_pkg::cml_oe_mode_t'(k);
				cyc(3);
				chk("oe0", ioPinOe_n[0], k == 0 ? 1'b0 : k == 1 ? 1'b1 : ~oeTerms[k[0]]);
				chk("oe8", ioPinOe_n[8], k == 0 ? 1'b0 : k == 1 ? 1'b1 : ~oeTerms[2 + k[0]]);
			end
		end
		mcCfg[0].oeMode = cml_pkg::CML_OE_OFF;
		extPin = 16'h0001;
		cyc(3);
		chk("fbSep", mcFeedback[0], 1'b0);
		$display("oe done");
	endtask : t_oe
	task automatic t_dff;
		setMc(2, cml_pkg::CML_MC_DFF, 2'h0, 16'h0001);
		ptTerms[2] = 1'b1;
		cyc(6);
		chk("noClk", mcFeedback[2], 1'b0);
		pulse(0);
		chk("dCap", mcFeedback[2], 1'b1);
		ptTerms[2] = 1'b0;
		mcCfg[2].clkSel = 2'h1;
		pulse(0);
		chk("otherClk", mcFeedback[2], 1'b1);
		pulse(1);
		chk("clk1", mcFeedback[2], 1'b0);
		mcCfg[2].clkSel = 2'h0;
		blkCfg.outClkInv = 1'b1;
		cyc(4);
		ptTerms[2] = 1'b1;
		insPinIn[0] = 1'b1;
		cyc(5);
		chk("riseIgn", mcFeedback[2], 1'b0);
		insPinIn[0] = 1'b0;
		cyc(5);
		chk("fallCap", mcFeedback[2], 1'b1);
		blkCfg.outClkInv = 1'b0;
		cyc(4);
		$display("dff done");
	endtask : t_dff
	task automatic t_tff;
		setMc(3, cml_pkg::CML_MC_TFF, 2'h0, 16'h0001);
		ptTerms[3] = 1'b1;
		pulse(0);
		chk("tog1", mcFeedback[3], 1'b1);
		pulse(0);
		chk("tog2", mcFeedback[3], 1'b0);
		ptTerms[3] = 1'b0;
		pulse(0);
		chk("togHold", mcFeedback[3], 1'b0);
		setMc(4, cml_pkg::CML_MC_LATCH, 2'h0, 16'h0001);
		insPinIn[0] = 1'b1;
		cyc(3);
		ptTerms[20] = 1'b1;
		cyc(3);
		chk("latOpen", mcFeedback[4], 1'b1);
		insPinIn[0] = 1'b0;
		cyc(4);
		ptTerms[20] = 1'b0;
		cyc(3);
		chk("latHeld", mcFeedback[4], 1'b1);
		$display("tff done");
	endtask : t_tff
	task automatic t_setrst;
		rstTerm = 1'b1;
		cyc(3);
		chk("rst", mcFeedback[2], 1'b0);
		setTerm = 1'b1;
		cyc(3);
		chk("rstWins", mcFeedback[2], 1'b0);
		rstTerm = 1'b0;
		cyc(3);
		chk("set", mcFeedback[2], 1'b1);
		setTerm = 1'b0;
		blkCfg.rstInv = 1'b1;
		cyc(3);
		chk("rstPol", mcFeedback[2], 1'b0);
		blkCfg.rstInv = 1'b0;
		blkCfg.setInv = 1'b1;
		cyc(3);
		chk("setPol", mcFeedback[2], 1'b1);
		blkCfg.setInv = 1'b0;
		cyc(3);
		$display("setrst done");
	endtask : t_setrst
	task automatic t_inputs;
		inCfg[3].mode = cml_pkg::CML_IN_REG;
		inCfg[4].mode = cml_pkg::CML_IN_DREG;
		inCfg[5].mode = cml_pkg::CML_IN_LATCH;
		cyc(2);
		insPinIn[2] = 1'b1;
		insPinIn[3] = 1'b1;
		insPinIn[4] = 1'b1;
		cyc(6);
		chk("inComb", inFeedback[2], 1'b1);
		chk("regWait", inFeedback[3], 1'b0);
		pulse(0);
		chk("regCap", inFeedback[3], 1'b1);
		chk("dreg1", inFeedback[4], 1'b0);
		pulse(0);
		chk("dreg2", inFeedback[4], 1'b1);
		insPinIn[0] = 1'b1;
		cyc(3);
		insPinIn[5] = 1'b1;
		cyc(4);
		chk("inLatOpen", inFeedback[5], 1'b1);
		insPinIn[0] = 1'b0;
		cyc(4);
		insPinIn[5] = 1'b0;
		cyc(4);
		chk("inLatHeld", inFeedback[5], 1'b1);
		inCfg[0].mode = cml_pkg::CML_IN_REG;
		cyc(2);
		insPinIn[0] = 1'b1;
		cyc(5);
		chk("selfClk", inFeedback[0], 1'b0);
		pulse(1);
		chk("otherPin", inFeedback[0], 1'b1);
		insPinIn[0] = 1'b0;
		blkCfg.inClkInv = 1'b1;
		cyc(6);
		insPinIn[3] = 1'b0;
		insPinIn[0] = 1'b1;
		cyc(5);
		chk("inRise", inFeedback[3], 1'b1);
		insPinIn[0] = 1'b0;
		cyc(5);
		chk("inFall", inFeedback[3], 1'b0);
		$display("inputs done");
	endtask : t_inputs
	task automatic t_buried;
		setMc(1, cml_pkg::CML_MC_DFF, 2'h3, 16'h0000);
		mcCfg[1].inRegEn = 1'b1;
		extPin = 16'h0001;
		cyc(4);
		chk("bWait", regFeedback[1], 1'b0);
		pulse(3);
		chk("bCap", regFeedback[1], 1'b1);
		chk("bNoPin", regPinOut[0], 1'b0);
		extPin = 16'h0000;
		pulse(3);
		chk("bCap0", regFeedback[1], 1'b0);
		mcCfg[1].inRegEn = 1'b0;
		$display("buried done");
	endtask : t_buried
	task automatic t_reset;
		insPinIn = '0;
		cyc(4);
		rst_n = 1'b0;
		cyc(2);
		chk("midOe", &{ioPinOe_n, regPinOe_n}, 1'b1);
		chk("midOut", |{mcFeedback, inFeedback, ioPinOut, regFeedback, regPinOut}, 1'b0);
		rst_n = 1'b1;
		cyc(3);
		chk("dHold", mcFeedback[2], 1'b0);
		chk("oeOff", ioPinOe_n[0], 1'b1);
		$display("reset done");
	endtask : t_reset
	// --------------------------------
	// run
	// --------------------------------
	initial begin
		repeat (20000) @(posedge mclk);
		errorCnt++;
		$display("[ERR] timeout exp done got hang");
		stop_test;
	end
	initial begin
		foreach (mcCfg[i]) mcCfg[i] = '0;
		foreach (inCfg[i]) inCfg[i] = '0;
		cyc(2);
		chk("rstOe", &ioPinOe_n, 1'b1);
		chk("rstOut", |{mcFeedback, inFeedback, ioPinOut}, 1'b0);
		rst_n = 1'b1;
		cyc(1);
		t_comb;
		t_oe;
		t_dff;
		t_tff;
		t_setrst;
		t_inputs;
		t_buried;
		t_reset;
		stop_test;
	end
endmodule : tb_cml_logic_block
